// *** qrs_map.vh ***
// Constants and overview for the quad rail reset supervisor with watchdog
// Overview of operation
// - Delay select open gives 20 ms release delay; tied high gives 300 ms.
// - Capacitor mode gives a programmable release delay, 1.4 ms to 10 s, per channel.
// - Watchdog period is 600 ms from channel 1 release or last kick edge.
// - Watchdog countdown starts when channel 1 hold is released.
// - Any rising or falling kick edge restarts the watchdog count.
// - Watchdog expiry without a kick edge asserts the watchdog fault output.
// - Fault is latched, ignores kicks, cleared only by channel 1 hold assertion.
// - Channel 1 releases after manual hold high, rail 1 good, and delay.
// - Channels 2 and 3 hold while rail low, release after delay once good.
// - Channel 4 holds on under or overvoltage, releases after delay when in range.
// - Assertion of a channel hold happens at once; only release waits.
// - Hold stays asserted for the whole delay after the release condition.
// - Asserted hold clears delay timing; timing restarts at next release condition.
`ifndef QRS_MAP_VH
`define QRS_MAP_VH

// ----------------------------------------
// Time base
// ----------------------------------------
`define QRS_CLK_HZ 10000000
`define QRS_TICK_US 100
`define QRS_TICK_CYC ((`QRS_CLK_HZ / 1000000) * `QRS_TICK_US)
`define QRS_TICK_LAST 10'h3e7
`define QRS_PRE_W 10

// ----------------------------------------
// Delays in ms, and in 100 us ticks
// ----------------------------------------
`define QRS_DLY_SHORT_MS 20
`define QRS_DLY_LONG_MS 300
`define QRS_WDT_MS 600
`define QRS_TICKS_PER_MS (1000 / `QRS_TICK_US)
`define QRS_CNT_W 17
// Tick counts sized to the counters: ms times ticks per ms
`define QRS_DLY_SHORT_T 17'h000c8
`define QRS_DLY_LONG_T 17'h00bb8
`define QRS_WDT_T 17'h01770
`define QRS_PROG_MIN_T 17'h0000e
`define QRS_PROG_MAX_T 17'h186a0

// ----------------------------------------
// Delay select modes
// ----------------------------------------
`define QRS_SEL_W 2
`define QRS_SEL_SHORT 2'h0
`define QRS_SEL_LONG 2'h1
`define QRS_SEL_PROG 2'h2

`endif

// *** qrs_sync.v ***
// Two-flop synchroniser for one level
`include "qrs_map.vh"

module qrs_sync (
    clk_sys,
    rst,
    din,
    dout
);
    input wire clk_sys;
    input wire rst;
    input wire din;
    output wire dout;

    reg meta_q;
    reg sync_q;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule

// *** qrs_chan.v ***
// One supervisor channel: instant assert, delayed release
`include "qrs_map.vh"

module qrs_chan (
    clk_sys,
    rst,
    tick,
    good,
    sel,
    prog_ticks,
    hold
);
    input wire clk_sys;
    input wire rst;
    input wire tick;
    input wire good;
    input wire [`QRS_SEL_W-1:0] sel;
    input wire [`QRS_CNT_W-1:0] prog_ticks;
    output reg hold;

    reg [`QRS_CNT_W-1:0] cnt_q;
    reg [`QRS_CNT_W-1:0] lim;
    reg [`QRS_CNT_W-1:0] prog_lim;

    // ----------------------------------------
    // Release delay target
    // ----------------------------------------
    always @* begin
        prog_lim = prog_ticks;
        if (prog_ticks < `QRS_PROG_MIN_T)
            prog_lim = `QRS_PROG_MIN_T;
        else if (prog_ticks > `QRS_PROG_MAX_T)
            prog_lim = `QRS_PROG_MAX_T;
        case (sel)
            `QRS_SEL_LONG: lim = `QRS_DLY_LONG_T;
            `QRS_SEL_PROG: lim = prog_lim;
            default: lim = `QRS_DLY_SHORT_T;
        endcase
    end

    // ----------------------------------------
    // Delay counter and hold state
    // ----------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= {`QRS_CNT_W{1'b0}};
            hold <= 1'b1;
        end else if (!good) begin
            cnt_q <= {`QRS_CNT_W{1'b0}};
            hold <= 1'b1;
        end else if (hold) begin
            // One extra tick so a partial first tick never shortens the delay
            if (cnt_q > lim)
                hold <= 1'b0;
            else if (tick)
                cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule

// *** qrs_supervisor.v ***
// Top of the quad rail reset supervisor with watchdog
`include "qrs_map.vh"

module qrs_supervisor (
    clk_sys,
    rst,
    manual_hold_n,
    watchdog_kick,
    rail_monitor_1,
    rail_monitor_2,
    rail_monitor_3,
    rail_monitor_4_low,
    rail_monitor_4_high,
    delay_select_1,
    delay_select_2,
    delay_select_3,
    delay_select_4,
    delay_prog_1,
    delay_prog_2,
    delay_prog_3,
    delay_prog_4,
    rail_hold_out_1,
    rail_hold_out_2,
    rail_hold_out_3,
    rail_hold_out_4,
    watchdog_fault_out
);
    input wire clk_sys;
    input wire rst;
    input wire manual_hold_n;
    input wire watchdog_kick;
    input wire rail_monitor_1;
    input wire rail_monitor_2;
    input wire rail_monitor_3;
    input wire rail_monitor_4_low;
    input wire rail_monitor_4_high;
    input wire [`QRS_SEL_W-1:0] delay_select_1;
    input wire [`QRS_SEL_W-1:0] delay_select_2;
    input wire [`QRS_SEL_W-1:0] delay_select_3;
    input wire [`QRS_SEL_W-1:0] delay_select_4;
    input wire [`QRS_CNT_W-1:0] delay_prog_1;
    input wire [`QRS_CNT_W-1:0] delay_prog_2;
    input wire [`QRS_CNT_W-1:0] delay_prog_3;
    input wire [`QRS_CNT_W-1:0] delay_prog_4;
    output reg rail_hold_out_1;
    output reg rail_hold_out_2;
    output reg rail_hold_out_3;
    output reg rail_hold_out_4;
    output reg watchdog_fault_out;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    wire [5:0] raw_in;
    wire [5:0] syn_in;
    assign raw_in = {watchdog_kick, rail_monitor_4_high, rail_monitor_4_low,
                     rail_monitor_3, rail_monitor_2, rail_monitor_1};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
            qrs_sync u_sync (
                .clk_sys(clk_sys),
                .rst(rst),
                .din(raw_in[gi]),
                .dout(syn_in[gi])
            );
        end
    endgenerate

    // Manual hold synchronised apart so its reset level is high (released)
    reg mh_meta_q;
    reg mh_q;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mh_meta_q <= 1'b1;
            mh_q <= 1'b1;
        end else begin
            mh_meta_q <= manual_hold_n;
            mh_q <= mh_meta_q;
        end
    end

    // ----------------------------------------
    // Tick prescaler
    // ----------------------------------------
    reg [`QRS_PRE_W-1:0] pre_q;
    reg tick_q;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pre_q <= {`QRS_PRE_W{1'b0}};
            tick_q <= 1'b0;
        end else if (pre_q == `QRS_TICK_LAST) begin
            pre_q <= {`QRS_PRE_W{1'b0}};
            tick_q <= 1'b1;
        end else begin
            pre_q <= pre_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Channel release conditions
    // ----------------------------------------
    wire [3:0] good;
    assign good[0] = mh_q & syn_in[0];
    assign good[1] = syn_in[1];
    assign good[2] = syn_in[2];
    assign good[3] = syn_in[3] & ~syn_in[4];

    wire [4*`QRS_SEL_W-1:0] sel_all;
    wire [4*`QRS_CNT_W-1:0] prog_all;
    wire [3:0] hold;
    assign sel_all = {delay_select_4, delay_select_3, delay_select_2, delay_select_1};
    assign prog_all = {delay_prog_4, delay_prog_3, delay_prog_2, delay_prog_1};

    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
            qrs_chan u_chan (
                .clk_sys(clk_sys),
                .rst(rst),
                .tick(tick_q),
                .good(good[gi]),
                .sel(sel_all[gi*`QRS_SEL_W +: `QRS_SEL_W]),
                .prog_ticks(prog_all[gi*`QRS_CNT_W +: `QRS_CNT_W]),
                .hold(hold[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // Watchdog on channel 1
    // ----------------------------------------
    reg kick_q;
    reg [`QRS_CNT_W-1:0] wd_cnt_q;
    wire kick_edge;
    assign kick_edge = syn_in[5] ^ kick_q;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            kick_q <= 1'b0;
            wd_cnt_q <= {`QRS_CNT_W{1'b0}};
            watchdog_fault_out <= 1'b0;
        end else begin
            kick_q <= syn_in[5];
            if (hold[0]) begin
                wd_cnt_q <= {`QRS_CNT_W{1'b0}};
                watchdog_fault_out <= 1'b0;
            end else if (!watchdog_fault_out) begin
                if (kick_edge)
                    wd_cnt_q <= {`QRS_CNT_W{1'b0}};
                else if (wd_cnt_q >= `QRS_WDT_T)
                    watchdog_fault_out <= 1'b1;
                else if (tick_q)
                    wd_cnt_q <= wd_cnt_q + 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rail_hold_out_1 <= 1'b1;
            rail_hold_out_2 <= 1'b1;
            rail_hold_out_3 <= 1'b1;
            rail_hold_out_4 <= 1'b1;
        end else begin
            rail_hold_out_1 <= hold[0];
            rail_hold_out_2 <= hold[1];
            rail_hold_out_3 <= hold[2];
            rail_hold_out_4 <= hold[3];
        end
    end
endmodule

// *** qrs_supervisor_asserts.sv ***
// Port checker for the quad rail reset supervisor
`include "qrs_map.vh"
module qrs_supervisor_chk (
    input wire clk_sys,
    input wire rst,
    input wire manual_hold_n,
    input wire watchdog_kick,
    input wire rail_monitor_1,
    input wire rail_monitor_2,
    input wire rail_monitor_4_low,
    input wire rail_monitor_4_high,
    input wire rail_hold_out_1,
    input wire rail_hold_out_2,
    input wire rail_hold_out_4,
    input wire watchdog_fault_out
);
    localparam int REL_MIN = `QRS_PROG_MIN_T * `QRS_TICK_CYC;
    localparam int WDT_MIN = 4500000;
    localparam int WDT_MAX = 7500000;
    logic [15:0] good_q;
    logic [23:0] quiet_q;
    logic kick_q;
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // ------
    // Rail 2 good time, time since kick edge or hold
    // ------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            good_q <= 16'h0000;
            quiet_q <= 24'h000000;
            kick_q <= 1'b0;
        end else begin
            kick_q <= watchdog_kick;
            good_q <= !rail_monitor_2 ? 16'h0000 : good_q + {15'h0000, !good_q[15]};
            if (rail_hold_out_1 || (watchdog_kick != kick_q)) begin
                quiet_q <= 24'h000000;
            end else begin
                quiet_q <= quiet_q + {23'h000000, !quiet_q[23]};
            end
        end
    end
    AST_CH1_HOLD: assert property ((!manual_hold_n || !rail_monitor_1) [*6] |-> rail_hold_out_1)
        else $error("channel 1 hold missing");
    AST_CH2_HOLD: assert property ((!rail_monitor_2) [*6] |-> rail_hold_out_2)
        else $error("channel 2 hold missing");
    AST_CH4_HOLD: assert property ((!rail_monitor_4_low || rail_monitor_4_high) [*6] |-> rail_hold_out_4)
        else $error("channel 4 hold missing");
    AST_REL_DELAY: assert property ($fell(rail_hold_out_2) |-> good_q >= REL_MIN)
        else $error("channel 2 released early");
    AST_HOLD_NO_FAULT: assert property (rail_hold_out_1 |-> !watchdog_fault_out)
        else $error("fault while channel 1 held");
    AST_FAULT_CLEAR: assert property ($fell(watchdog_fault_out) |=> rail_hold_out_1)
        else $error("fault cleared without hold");
    AST_WDT_EARLY: assert property ($rose(watchdog_fault_out) |-> quiet_q >= WDT_MIN)
        else $error("watchdog expired early");
    AST_WDT_LATE: assert property (!rail_hold_out_1 && quiet_q >= WDT_MAX |-> watchdog_fault_out)
        else $error("watchdog expiry missed");
    cover property ($fell(rail_hold_out_1));
    cover property ($fell(rail_hold_out_4));
    cover property ($rose(rail_hold_out_2));
endmodule

bind qrs_supervisor qrs_supervisor_chk u_qrs_supervisor_chk (
    .clk_sys, .rst, .manual_hold_n, .watchdog_kick, .rail_monitor_1, .rail_monitor_2,
    .rail_monitor_4_low, .rail_monitor_4_high, .rail_hold_out_1, .rail_hold_out_2,
    .rail_hold_out_4, .watchdog_fault_out
);

// *** qrs_cpu_model.sv ***
// Processor model that services the watchdog while out of reset
module qrs_cpu_model (
    input wire logic clk_sys,
    input wire logic hold_in,
    output logic kick
);
    timeunit 1ns;
    timeprecision 1ns;
    int gap = 0;
    logic kick_q = 1'b0;
    assign kick = kick_q;
    always @(negedge clk_sys) begin
        if (hold_in) begin
            gap <= 0;
        end else if (gap == 2499) begin
            gap <= 0;
            kick_q <= ~kick_q;
        end else begin
            gap <= gap + 1;
        end
    end
endmodule

// *** tb_qrs_supervisor.sv ***
// Bench for the quad rail reset supervisor
`include "qrs_map.vh"
module tb_qrs_supervisor;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int REL = `QRS_PROG_MIN_T * `QRS_TICK_CYC;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [5:0] ok = 6'h3f;
    logic [16:0] prog = 17'h0000e;
    logic [7:0] sel = 8'haa;
    wire [3:0] hold;
    wire fault;
    wire kick;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    always #50 clk_sys = ~clk_sys;
    qrs_supervisor u_qrs_supervisor (
        .clk_sys(clk_sys), .rst(rst), .watchdog_kick(kick),
        .manual_hold_n(ok[0] & !fault),
        .rail_monitor_1(ok[1]), .rail_monitor_2(ok[2]), .rail_monitor_3(ok[3]),
        .rail_monitor_4_low(ok[4]), .rail_monitor_4_high(!ok[5]),
        .delay_select_1(sel[1:0]), .delay_select_2(sel[3:2]), .delay_select_3(sel[5:4]),
        .delay_select_4(sel[7:6]), .delay_prog_1(prog), .delay_prog_2(prog),
        .delay_prog_3(prog), .delay_prog_4(prog), .rail_hold_out_1(hold[0]),
        .rail_hold_out_2(hold[1]), .rail_hold_out_3(hold[2]), .rail_hold_out_4(hold[3]),
        .watchdog_fault_out(fault)
    );
    qrs_cpu_model u_qrs_cpu_model (.clk_sys(clk_sys), .hold_in(hold[0]), .kick(kick));
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic release_check(input logic [3:0] which, input logic [3:0] keep);
        int n;
        n = 0;
        repeat (REL - 10) @(negedge clk_sys);
        check(hold & which, which);
        while (hold !== keep && n < 1200) begin
            @(negedge clk_sys);
            n++;
        end
        check(hold, keep);
    endtask
    // Adds one more fault on top of those already applied
    task automatic fault_step(input int bit_n, input logic [3:0] exp);
        ok[bit_n] = 1'b0;
        repeat (8) @(negedge clk_sys);
        check(hold, exp);
        check({3'h0, fault}, 4'h0);
    endtask
    task automatic test_power_up();
        check(hold, 4'hf);
        check({3'h0, fault}, 4'h0);
        release_check(4'hf, 4'h0);
        $display("test_power_up done");
    endtask
    task automatic test_each_fault();
        prog = 17'h00001;
        fault_step(0, 4'h1);
        fault_step(2, 4'h3);
        fault_step(3, 4'h7);
        fault_step(5, 4'hf);
        ok = 6'h3f;
        release_check(4'hf, 4'h0);
        fault_step(1, 4'h1);
        fault_step(4, 4'h9);
        ok = 6'h3f;
        release_check(4'h9, 4'h0);
        $display("test_each_fault done");
    endtask
    // Channel 3 short and channel 4 long, channel 2 glitched mid delay
    task automatic test_fixed_delay();
        sel = 8'h4a;
        fault_step(2, 4'h2);
        fault_step(3, 4'h6);
        fault_step(4, 4'he);
        ok = 6'h3f;
        repeat (REL / 2) @(negedge clk_sys);
        ok[2] = 1'b0;
        repeat (2) @(negedge clk_sys);
        ok[2] = 1'b1;
        release_check(4'he, 4'hc);
        $display("test_fixed_delay done");
    endtask
    task automatic test_watchdog();
        check({3'h0, fault}, 4'h0);
        repeat (6000) @(negedge clk_sys);
        check({3'h0, fault}, 4'h0);
        check(hold, 4'hc);
        $display("test_watchdog done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        test_power_up();
        test_each_fault();
        test_fixed_delay();
        test_watchdog();
        results();
    end
endmodule
